/* File: include/ufc_pkg.sv */
package ufc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] A_MCR = 4'h0;
  localparam logic [3:0] A_LCR = 4'h1;
  localparam logic [3:0] A_IER = 4'h2;
  localparam logic [3:0] A_ISR = 4'h3;
  localparam logic [3:0] A_EFR = 4'h4;
  localparam logic [3:0] A_FEATURE_CONTROL_REG = 4'h5;
  localparam logic [3:0] A_MSR = 4'h6;
  localparam logic [3:0] A_CHR0 = 4'h7;
  localparam logic [3:0] A_STAT = 4'hb;
  localparam int NUM_CHR = 4;
  localparam int CHR_FIRST_RESUME_CHAR = 0;
  localparam int CHR_SECOND_STOP_CHAR = 3;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_PAIR = 2;
  localparam int EFR_SWRX = 0;
  localparam int EFR_SWTX = 2;
  localparam int EFR_UNLOCK = 4;
  localparam int EFR_SPECIAL = 5;
  localparam int EFR_AUTO_REQ = 6;
  localparam int EFR_AUTO_CLR = 7;
  localparam int IER_XOFF = 5;
  localparam int IER_REQ = 6;
  localparam int IER_CLR = 7;
  localparam int ISR_XOFF = 4;
  localparam int ISR_FLOW = 5;
  localparam int FEATURE_CONTROL_REG_TRIG = 0;
  localparam int FEATURE_CONTROL_REG_HDX = 5;
  localparam int MSR_TURN = 4;
  localparam int LCR_WL = 0;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] SW_OFF = 2'h0;
  localparam logic [1:0] SW_CH2 = 2'h2;
  localparam logic [1:0] SW_BOTH = 2'h3;
  localparam logic [4:0] LVL_0 = 5'h00;
  localparam logic [4:0] LVL_1 = 5'h01;
  localparam logic [4:0] LVL_4 = 5'h04;
  localparam logic [4:0] LVL_8 = 5'h08;
  localparam logic [4:0] LVL_14 = 5'h0e;
  localparam logic [4:0] LVL_16 = 5'h10;
  localparam logic [4:0] WL_BASE = 5'h05;
  localparam logic [4:0] FRAME_EXTRA = 5'h02;
  localparam int CHAR_TIMES = 2;

  typedef enum logic [2:0] {
    UFC_IDLE = 3'b000,
    UFC_WAIT = 3'b001,
    UFC_OFF = 3'b010,
    UFC_HELD = 3'b011,
    UFC_ON = 3'b100
  } ufc_state_t;

endpackage

/* File: design/ufc_flow_ctrl.sv */
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module ufc_flow_ctrl
  import ufc_pkg::*;
#(
  parameter int LVL_W = 5
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  input wire logic [LVL_W-1:0] RX_LEVEL,
  input wire logic RX_FULL,
  output logic RX_PUSH,
  output logic [7:0] RX_PUSH_DATA,
  input wire logic TX_FIFO_EMPTY,
  input wire logic TX_SHIFT_BUSY,
  input wire logic BIT_TICK,
  output logic TX_ALLOW,
  output logic TX_INS_VALID,
  output logic [7:0] TX_INS_DATA,
  input wire logic TX_INS_TAKEN,
  input wire logic CTS_N,
  input wire logic DSR_N,
  output logic RTS_N,
  output logic DTR_N,
  output logic IRQ,
  output logic TX_EMPTY_IRQ
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Address hit for a write or read strobe
  function automatic logic hit(input logic strobe, input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = strobe & (a == off);
  endfunction

  // Masked compare over the programmed word length
  function automatic logic chr_eq(input logic [7:0] a, input logic [7:0] b,
                                  input logic [1:0] wl);
    logic [7:0] m;
    m = 8'hff >> (2'h3 - wl);
    chr_eq = ((a ^ b) & m) == 8'h00;
  endfunction

  // Level below, trigger level, next level above, for steps 0, 1 and 2
  function automatic logic [4:0] lvl_of(input logic [1:0] s, input logic [1:0] step);
    logic [4:0] t [4];
    t[0] = LVL_0;
    t[1] = LVL_1;
    t[2] = LVL_4;
    t[3] = LVL_8;
    lvl_of = LVL_0;
    case (step)
      2'h0: lvl_of = (s == 2'h3) ? LVL_8 : t[s];
      2'h1: lvl_of = (s == 2'h0) ? LVL_1 : (s == 2'h1) ? LVL_4 :
                     (s == 2'h2) ? LVL_8 : LVL_14;
      default: lvl_of = (s == 2'h0) ? LVL_4 : (s == 2'h1) ? LVL_8 :
                        (s == 2'h2) ? LVL_14 : LVL_16;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] mcr_reg, lcr_reg, ier_reg, efr_reg, feature_control_reg_reg, msr_reg;
  logic [7:0] chr_reg [NUM_CHR];
  logic isr_xoff_reg, isr_flow_reg;
  logic req_hold_reg, xoff_hold_reg, clr_d_reg, dir_n_reg;
  logic first_off_reg, first_on_reg, second_reg;
  logic [4:0] wait_cnt_reg;
  logic [3:0] turn_cnt_reg;
  ufc_state_t state_reg, state_next;

  // Register writes
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mcr_reg <= RESET_BYTE;
      lcr_reg <= RESET_BYTE;
      ier_reg <= RESET_BYTE;
      efr_reg <= RESET_BYTE;
      feature_control_reg_reg <= RESET_BYTE;
      msr_reg <= RESET_BYTE;
    end else begin
      if (hit(WR, ADDR, A_MCR)) mcr_reg <= WDATA;
      if (hit(WR, ADDR, A_LCR)) lcr_reg <= WDATA;
      if (hit(WR, ADDR, A_IER)) ier_reg <= WDATA;
      if (hit(WR, ADDR, A_EFR)) efr_reg <= WDATA;
      if (hit(WR, ADDR, A_FEATURE_CONTROL_REG)) feature_control_reg_reg <= WDATA;
      if (hit(WR, ADDR, A_MSR)) msr_reg <= WDATA;
    end
  end

  // Flow-control character registers
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHR; gi++) begin : g_chr
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          chr_reg[gi] <= RESET_BYTE;
        end else if (hit(WR, ADDR, A_CHR0 + ADDR_W'(gi))) begin
          chr_reg[gi] <= WDATA;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire pair_dtr = mcr_reg[MCR_PAIR];
  wire auto_req = efr_reg[EFR_AUTO_REQ];
  wire auto_clr = efr_reg[EFR_AUTO_CLR];
  wire unlock = efr_reg[EFR_UNLOCK];
  wire hdx = feature_control_reg_reg[FEATURE_CONTROL_REG_HDX];
  wire [1:0] wl = lcr_reg[LCR_WL +: 2];
  wire [1:0] trig_sel = feature_control_reg_reg[FEATURE_CONTROL_REG_TRIG +: 2];
  wire [1:0] sw_rx = efr_reg[EFR_SWRX +: 2];
  wire [1:0] sw_tx = efr_reg[EFR_SWTX +: 2];
  wire [3:0] turn_dly = msr_reg[MSR_TURN +: 4];
  wire [LVL_W-1:0] lvl_low = LVL_W'(lvl_of(trig_sel, 2'h0));
  wire [LVL_W-1:0] lvl_trig = LVL_W'(lvl_of(trig_sel, 2'h1));
  wire [LVL_W-1:0] lvl_high = LVL_W'(lvl_of(trig_sel, 2'h2));

  // ----------------------------------------------------------------
  // Receive side request throttling
  // ----------------------------------------------------------------
  wire lvl_at_high = RX_LEVEL >= lvl_high;
  wire lvl_at_low = RX_LEVEL <= lvl_low;
  wire req_hold_next = !auto_req ? 1'b0 :
                       lvl_at_high ? 1'b1 :
                       lvl_at_low ? 1'b0 : req_hold_reg;
  wire sel_bit = pair_dtr ? mcr_reg[MCR_DTR] : mcr_reg[MCR_RTS];
  // In half duplex the pin follows the direction flop: high while sending
  wire sel_pin_next = hdx ? dir_n_reg : ~(sel_bit & ~req_hold_reg);
  wire rts_n_next = pair_dtr ? ~mcr_reg[MCR_RTS] : sel_pin_next;
  wire dtr_n_next = pair_dtr ? sel_pin_next : ~mcr_reg[MCR_DTR];
  wire sel_pin_now = pair_dtr ? DTR_N : RTS_N;
  wire req_edge = sel_pin_next != sel_pin_now;

  // ----------------------------------------------------------------
  // Clear-line monitor
  // ----------------------------------------------------------------
  wire clr_in_n = pair_dtr ? DSR_N : CTS_N;
  wire clr_edge = clr_in_n != clr_d_reg;
  wire clr_hold = auto_clr & clr_in_n;

  // ----------------------------------------------------------------
  // Received character compare
  // ----------------------------------------------------------------
  wire m_on1 = chr_eq(RX_DATA, chr_reg[0], wl);
  wire m_on2 = chr_eq(RX_DATA, chr_reg[1], wl);
  wire m_off1 = chr_eq(RX_DATA, chr_reg[2], wl);
  wire m_off2 = chr_eq(RX_DATA, chr_reg[3], wl);
  wire xoff_m = (sw_rx == SW_BOTH) ? (first_off_reg & m_off2) :
                (sw_rx == SW_CH2) ? m_off2 : m_off1;
  wire xon_m = (sw_rx == SW_BOTH) ? (first_on_reg & m_on2) :
               (sw_rx == SW_CH2) ? m_on2 : m_on1;
  wire sw_on = sw_rx != SW_OFF;
  wire xoff_hit = RX_VALID & sw_on & xoff_m;
  wire xon_hit = RX_VALID & sw_on & xon_m & xoff_hold_reg;
  wire special_hit = RX_VALID & efr_reg[EFR_SPECIAL] & m_off2;
  wire flow_hit = xoff_hit | (RX_VALID & sw_on & xon_m);
  wire push_next = RX_VALID & ~RX_FULL & (special_hit | ~flow_hit);
  wire xoff_hold_next = !sw_on ? 1'b0 : xoff_hit ? 1'b1 :
                        xon_hit ? 1'b0 : xoff_hold_reg;

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  wire isr_rd = hit(RD, ADDR, A_ISR);
  wire flow_set = unlock & ((ier_reg[IER_REQ] & req_edge) |
                            (ier_reg[IER_CLR] & clr_edge));
  wire xoff_set = (ier_reg[IER_XOFF] & xoff_hit) | special_hit;
  wire isr_flow_next = flow_set | (isr_flow_reg & ~isr_rd);
  wire isr_xoff_next = xoff_set | (isr_xoff_reg & ~isr_rd & ~xon_hit);

  // ----------------------------------------------------------------
  // Automatic stop/resume character transmit
  // ----------------------------------------------------------------
  wire [4:0] char_bits = WL_BASE + 5'(wl) + FRAME_EXTRA;
  wire [4:0] wait_len = 5'(CHAR_TIMES * char_bits);
  wire wait_done = BIT_TICK & (wait_cnt_reg == wait_len - 5'h01);
  wire last_chr = (sw_tx != SW_BOTH) | second_reg;

  // Send sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      UFC_IDLE: if (sw_tx != SW_OFF && RX_LEVEL >= lvl_trig) state_next = UFC_WAIT;
      UFC_WAIT: if (wait_done) state_next = UFC_OFF;
      UFC_OFF: if (TX_INS_TAKEN && last_chr) state_next = UFC_HELD;
      UFC_HELD: if (lvl_at_low) state_next = UFC_ON;
      UFC_ON: if (TX_INS_TAKEN && last_chr) state_next = UFC_IDLE;
      default: state_next = UFC_IDLE;
    endcase
  end

  wire second_next = (state_reg == UFC_OFF || state_reg == UFC_ON) &&
                     TX_INS_TAKEN && !last_chr;
  wire ins_next = state_next == UFC_OFF || state_next == UFC_ON;
  wire use2 = (sw_tx == SW_CH2) | second_next | (second_reg & ~TX_INS_TAKEN);
  wire [1:0] ins_idx = {state_next == UFC_OFF, use2};

  // ----------------------------------------------------------------
  // Half-duplex direction and transmit gating
  // ----------------------------------------------------------------
  wire tsr_empty = TX_FIFO_EMPTY & ~TX_SHIFT_BUSY;
  wire tx_pending = ~TX_FIFO_EMPTY | TX_INS_VALID;
  wire turn_wait = dir_n_reg & tsr_empty & ~tx_pending;
  wire dir_n_next = !hdx ? 1'b0 :
                    tx_pending ? 1'b1 :
                    (turn_wait && turn_cnt_reg == turn_dly) ? 1'b0 :
                    dir_n_reg;
  wire allow_next = ~clr_hold & ~xoff_hold_reg & (~hdx | dir_n_reg);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (ADDR)
      A_MCR: rd_mux = mcr_reg;
      A_LCR: rd_mux = lcr_reg;
      A_IER: rd_mux = ier_reg;
      A_ISR: rd_mux = {2'h0, isr_flow_reg, isr_xoff_reg, 4'h0};
      A_EFR: rd_mux = efr_reg;
      A_FEATURE_CONTROL_REG: rd_mux = feature_control_reg_reg;
      A_MSR: rd_mux = {msr_reg[7:4], 2'h0, DSR_N, CTS_N};
      A_STAT: rd_mux = {3'h0, dir_n_reg, clr_hold, xoff_hold_reg, req_hold_reg, TX_ALLOW};
      default: rd_mux = (ADDR >= A_CHR0 && ADDR < A_STAT) ? chr_reg[2'(ADDR - A_CHR0)] :
                        8'h00;
    endcase
  end

  // Read data and status state
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
      isr_flow_reg <= 1'b0;
      isr_xoff_reg <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      RDATA <= RD ? rd_mux : 8'h00;
      isr_flow_reg <= isr_flow_next;
      isr_xoff_reg <= isr_xoff_next;
      IRQ <= isr_flow_next | isr_xoff_next;
    end
  end

  // Receive path and flow holds
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      req_hold_reg <= 1'b0;
      xoff_hold_reg <= 1'b0;
      first_off_reg <= 1'b0;
      first_on_reg <= 1'b0;
      clr_d_reg <= 1'b1;
      RX_PUSH <= 1'b0;
      RX_PUSH_DATA <= 8'h00;
    end else begin
      req_hold_reg <= req_hold_next;
      xoff_hold_reg <= xoff_hold_next;
      clr_d_reg <= clr_in_n;
      if (RX_VALID) first_off_reg <= m_off1;
      if (RX_VALID) first_on_reg <= m_on1;
      RX_PUSH <= push_next;
      if (RX_VALID) RX_PUSH_DATA <= RX_DATA;
    end
  end

  // Sequencer, turnaround and pins
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= UFC_IDLE;
      second_reg <= 1'b0;
      wait_cnt_reg <= 5'h00;
      turn_cnt_reg <= 4'h0;
      dir_n_reg <= 1'b0;
      TX_INS_VALID <= 1'b0;
      TX_INS_DATA <= 8'h00;
      TX_ALLOW <= 1'b0;
      RTS_N <= 1'b1;
      DTR_N <= 1'b1;
      TX_EMPTY_IRQ <= 1'b0;
    end else begin
      state_reg <= state_next;
      second_reg <= second_next | (second_reg & ~TX_INS_TAKEN);
      wait_cnt_reg <= (state_reg != UFC_WAIT) ? 5'h00 : wait_cnt_reg + 5'(BIT_TICK);
      turn_cnt_reg <= !turn_wait ? 4'h0 : turn_cnt_reg + 4'(BIT_TICK);
      dir_n_reg <= dir_n_next;
      TX_INS_VALID <= ins_next;
      TX_INS_DATA <= chr_reg[ins_idx];
      TX_ALLOW <= allow_next;
      RTS_N <= rts_n_next;
      DTR_N <= dtr_n_next;
      TX_EMPTY_IRQ <= hdx ? tsr_empty : TX_FIFO_EMPTY;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  req_throttle_a: assert property (
    auto_req && lvl_at_high |=> req_hold_reg ##1 (!sel_bit || hdx || sel_pin_now))
    else $error("request not released at upper level");

  req_resume_a: assert property (
    auto_req && lvl_at_low && !lvl_at_high |=> !req_hold_reg)
    else $error("request not reasserted at lower level");

  flow_char_drop_a: assert property (
    flow_hit && !special_hit |=> !RX_PUSH)
    else $error("flow character stored");

  push_until_full_a: assert property (
    RX_VALID && !RX_FULL && !flow_hit |=> RX_PUSH && RX_PUSH_DATA == $past(RX_DATA))
    else $error("character not accepted");

  clear_stop_a: assert property (
    clr_hold |=> !TX_ALLOW)
    else $error("transmit allowed while clear input high");

  clr_irq_a: assert property (
    unlock && ier_reg[IER_CLR] && clr_edge |=> isr_flow_reg && IRQ)
    else $error("clear transition lost");

  xoff_halt_a: assert property (
    xoff_hit |=> xoff_hold_reg ##1 !TX_ALLOW)
    else $error("stop match did not halt");

  dir_first_a: assert property (
    hdx && $past(hdx) && TX_ALLOW |-> $past(dir_n_reg) && sel_pin_now)
    else $error("transmit allowed with direction low");

  tsr_irq_a: assert property (
    hdx && $stable(hdx) |=> TX_EMPTY_IRQ == $past(tsr_empty))
    else $error("half duplex empty interrupt wrong source");

endmodule

/* File: verif/ufc_remote.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Far-side transmitter model: bit timing, shifter, inserted chars
// ----------------------------------------------------------------
module ufc_remote (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic slow,
  input wire logic ins_valid,
  output logic bit_tick,
  output logic busy,
  output logic taken
);
  logic [1:0] div_reg;
  logic [3:0] bits_reg;
  logic [1:0] wait_reg;
  // Shifter stays busy for ten bit times per character
  assign busy = (bits_reg != 4'h0);
  // Tick every fourth cycle, take inserted chars promptly or slowly
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 2'h0;
      bits_reg <= 4'h0;
      wait_reg <= 2'h0;
      taken <= 1'b0;
      bit_tick <= 1'b0;
    end else begin
      div_reg <= div_reg + 2'h1;
      bit_tick <= (div_reg == 2'h3);
      taken <= 1'b0;
      if (go) begin
        bits_reg <= 4'ha;
      end else if (ins_valid && !taken && !busy) begin
        if (!slow || wait_reg == 2'h3) begin
          taken <= 1'b1;
          bits_reg <= 4'ha;
          wait_reg <= 2'h0;
        end else begin
          wait_reg <= wait_reg + 2'h1;
        end
      end else if (bit_tick && busy) begin
        bits_reg <= bits_reg - 4'h1;
      end
    end
  end
endmodule

/* File: verif/uart_flow_control_tb.sv */
`timescale 1ns/1ps
module uart_flow_control_tb;
  import ufc_pkg::*;
  logic CLK, RST_N, WR, RD, RX_VALID, RX_FULL, TX_FIFO_EMPTY, CTS_N, DSR_N, go, slow, rd_s;
  logic [3:0] ADDR;
  logic [7:0] WDATA, RX_DATA, x;
  logic [4:0] RX_LEVEL;
  wire logic [7:0] RDATA, RX_PUSH_DATA, TX_INS_DATA;
  wire logic RX_PUSH, TX_SHIFT_BUSY, BIT_TICK, TX_ALLOW, TX_INS_VALID, TX_INS_TAKEN;
  wire logic RTS_N, DTR_N, IRQ, TX_EMPTY_IRQ;
  logic [7:0] exp_rd[$], exp_push[$], exp_ins[$];
  int n_fail = 0, check_count = 0, cyc = 0, n;
  ufc_flow_ctrl ufc_flow_ctrl_inst (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA),
    .RX_LEVEL(RX_LEVEL), .RX_FULL(RX_FULL), .RX_PUSH(RX_PUSH), .RX_PUSH_DATA(RX_PUSH_DATA),
    .TX_FIFO_EMPTY(TX_FIFO_EMPTY), .TX_SHIFT_BUSY(TX_SHIFT_BUSY), .BIT_TICK(BIT_TICK),
    .TX_ALLOW(TX_ALLOW), .TX_INS_VALID(TX_INS_VALID), .TX_INS_DATA(TX_INS_DATA),
    .TX_INS_TAKEN(TX_INS_TAKEN), .CTS_N(CTS_N), .DSR_N(DSR_N), .RTS_N(RTS_N),
    .DTR_N(DTR_N), .IRQ(IRQ), .TX_EMPTY_IRQ(TX_EMPTY_IRQ));
  ufc_remote ufc_remote_inst (.clk(CLK), .rst_n(RST_N), .go(go), .slow(slow),
    .ins_valid(TX_INS_VALID), .bit_tick(BIT_TICK), .busy(TX_SHIFT_BUSY),
    .taken(TX_INS_TAKEN));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge CLK);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    // Let an edge pass so a following strobe is not assigned in the same step
    @(posedge CLK);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_rd.push_back(e);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rx(input logic [7:0] d, input bit push);
    if (push) exp_push.push_back(d);
    RX_DATA <= d;
    RX_VALID <= 1'b1;
    @(posedge CLK);
    RX_VALID <= 1'b0;
    @(posedge CLK);
  endtask
  // Pin select: 0 request, 1 ready, 2 allow, 3 insert, 4 empty irq, 5 irq
  function automatic logic pin(input int k);
    logic [5:0] v;
    v = {IRQ, TX_EMPTY_IRQ, TX_INS_VALID, TX_ALLOW, DTR_N, RTS_N};
    return v[k];
  endfunction
  task automatic expect_pin(input string what, input int k, input logic e, input int lim);
    int i;
    i = 0;
    @(negedge CLK);
    while (pin(k) !== e && i < lim) begin
      @(negedge CLK);
      i++;
    end
    check(what, {7'h0, pin(k)}, {7'h0, e});
    @(posedge CLK);
  endtask
  // ----------------------------------------------------------------
  // Result watcher: takes the oldest note for each result seen
  // ----------------------------------------------------------------
  always @(posedge CLK) rd_s <= RD;
  always @(negedge CLK) begin
    if (rd_s === 1'b1) check("rdata", RDATA, exp_rd.pop_front());
    if (RX_PUSH === 1'b1) begin
      if (exp_push.size() == 0) check("push", 8'h01, 8'h00);
      else check("push_data", RX_PUSH_DATA, exp_push.pop_front());
    end
    if (TX_INS_VALID === 1'b1 && TX_INS_TAKEN === 1'b1) begin
      if (exp_ins.size() == 0) check("insert", 8'h01, 8'h00);
      else check("insert_data", TX_INS_DATA, exp_ins.pop_front());
    end
  end
  // Clock and hang limit
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      check("timeout", 8'h01, 8'h00);
      complete_run();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    RST_N = 1'b0; WR = 1'b0; RD = 1'b0; ADDR = 4'h0; WDATA = 8'h00; RX_VALID = 1'b0;
    RX_DATA = 8'h00; RX_LEVEL = 5'h00; RX_FULL = 1'b0; TX_FIFO_EMPTY = 1'b1;
    CTS_N = 1'b0; DSR_N = 1'b0; go = 1'b0; slow = 1'b0;
    void'($urandom(29));
    idle(3);
    RST_N <= 1'b1;
    @(posedge CLK);
    for (int a = 0; a < 16; a++) if (a != 11) rd(a[3:0], 8'h00);
    rd(A_STAT, 8'h01);
    for (int a = 7; a < 11; a++) begin
      x = 8'($urandom());
      wr(a[3:0], x);
      rd(a[3:0], x);
    end
    wr(4'hc, 8'h5a);
    rd(4'hc, 8'h00);
    for (int i = 0; i < 4; i++) rx(8'($urandom()), 1'b1);
    RX_FULL <= 1'b1;
    rx(8'h33, 1'b0);
    RX_FULL <= 1'b0;
    $display("registers and receive path done");
    // Single stop/resume with 5-bit words
    wr(4'h9, 8'h13); wr(4'h7, 8'h11); wr(A_IER, 8'h20); wr(A_EFR, 8'h01);
    rx(8'hf3, 1'b0);
    expect_pin("allow", 2, 1'b0, 8);
    expect_pin("irq", 5, 1'b1, 4);
    rd(A_ISR, 8'h10);
    rx(8'h42, 1'b1);
    expect_pin("allow", 2, 1'b0, 0);
    rx(8'h11, 1'b0);
    expect_pin("allow", 2, 1'b1, 8);
    rd(A_STAT, 8'h01);
    // Double pairs with 8-bit words
    wr(A_LCR, 8'h03); wr(4'ha, 8'h93); wr(4'h8, 8'h91); wr(A_EFR, 8'h03);
    rx(8'h13, 1'b1);
    rx(8'h93, 1'b0);
    expect_pin("allow", 2, 1'b0, 8);
    rd(A_ISR, 8'h10);
    rx(8'h11, 1'b1);
    rx(8'h91, 1'b0);
    expect_pin("allow", 2, 1'b1, 8);
    rd(A_ISR, 8'h00);
    wr(A_EFR, 8'h20);
    rx(8'h93, 1'b1);
    rd(A_ISR, 8'h10);
    $display("software flow done");
    // Request line, both pairs, trigger 4
    wr(A_EFR, 8'h00); wr(A_FEATURE_CONTROL_REG, 8'h01); wr(A_IER, 8'h40);
    for (int p = 0; p < 2; p++) begin
      wr(A_EFR, 8'h50);
      wr(A_MCR, p ? 8'h05 : 8'h02);
      expect_pin("req", p, 1'b0, 4);
      RX_LEVEL <= 5'h04;
      idle(6);
      expect_pin("req", p, 1'b0, 0);
      RX_LEVEL <= 5'h08;
      expect_pin("req", p, 1'b1, 6);
      expect_pin("other", 1 - p, 1'b1, 0);
      RX_LEVEL <= 5'h02;
      idle(6);
      expect_pin("req", p, 1'b1, 0);
      RX_LEVEL <= 5'h01;
      expect_pin("req", p, 1'b0, 6);
      rd(A_ISR, 8'h20);
      wr(A_EFR, 8'h00);
      wr(A_MCR, 8'h00);
    end
    wr(A_MCR, 8'h02);
    RX_LEVEL <= 5'h08;
    idle(6);
    expect_pin("req", 0, 1'b0, 0);
    wr(A_MCR, 8'h00);
    RX_LEVEL <= 5'h00;
    $display("request line done");
    // Clear line
    CTS_N <= 1'b1;
    idle(4);
    expect_pin("allow", 2, 1'b1, 0);
    CTS_N <= 1'b0;
    idle(2);
    wr(A_IER, 8'h80); wr(A_EFR, 8'h90);
    CTS_N <= 1'b1;
    expect_pin("allow", 2, 1'b0, 3);
    CTS_N <= 1'b0;
    expect_pin("allow", 2, 1'b1, 3);
    rd(A_ISR, 8'h20);
    wr(A_IER, 8'h00); wr(A_EFR, 8'h00);
    $display("clear line done");
    // Automatic stop and resume characters, trigger 1
    wr(A_FEATURE_CONTROL_REG, 8'h00); wr(A_EFR, 8'h04);
    slow <= 1'b1;
    exp_ins.push_back(8'h13);
    exp_ins.push_back(8'h11);
    RX_LEVEL <= 5'h01;
    n = 0;
    for (int i = 0; i < 400 && TX_INS_VALID !== 1'b1; i++) begin
      @(negedge CLK);
      if (BIT_TICK === 1'b1) n++;
    end
    @(posedge CLK);
    // Two characters of start, eight data bits and stop, one tick of slack
    check("char_wait", {7'h0, n >= 2 * (1 + 8 + 1) - 1 && n <= 2 * (1 + 8 + 1) + 1}, 8'h01);
    idle(60);
    RX_LEVEL <= 5'h00;
    for (int i = 0; i < 300 && exp_ins.size() != 0; i++) @(posedge CLK);
    check("resume_sent", 8'(exp_ins.size()), 8'h00);
    wr(A_EFR, 8'h00);
    $display("automatic send done");
    // Half-duplex direction with turnaround of three bit times
    wr(A_FEATURE_CONTROL_REG, 8'h20); wr(A_MSR, 8'h30);
    TX_FIFO_EMPTY <= 1'b0;
    expect_pin("dir", 0, 1'b1, 3);
    go <= 1'b1;
    @(posedge CLK);
    go <= 1'b0;
    TX_FIFO_EMPTY <= 1'b1;
    idle(8);
    expect_pin("empty_irq", 4, 1'b0, 0);
    for (int i = 0; i < 200 && TX_SHIFT_BUSY !== 1'b0; i++) @(negedge CLK);
    n = 0;
    for (int i = 0; i < 200 && RTS_N !== 1'b0; i++) begin
      @(negedge CLK);
      if (BIT_TICK === 1'b1) n++;
    end
    @(posedge CLK);
    check("turnaround", {7'h0, n >= 3 && n <= 4}, 8'h01);
    expect_pin("empty_irq", 4, 1'b1, 4);
    $display("half duplex done");
    idle(4);
    complete_run();
  end
endmodule
